// File: core/chan_pkg.sv
// Shared constants for the channel filter and mailbox block.
// Assumes an 8-bit host byte map and 14 channel register sets.
package chan_pkg;

    // ------------------------------------------------------------
    // Byte map
    // ------------------------------------------------------------
    localparam int        NUM_CH      = 14;
    localparam logic [7:0] CH_BASE    = 8'h10;
    localparam logic [7:0] MBOX_BASE  = 8'h80;
    localparam int        MBOX_DEPTH  = 128;
    localparam logic [2:0] OFS_ID_UP  = 3'h0;
    localparam logic [2:0] OFS_ID_LO  = 3'h1;
    localparam logic [2:0] OFS_PTR    = 3'h2;
    localparam logic [2:0] OFS_LEN    = 3'h3;
    localparam logic [2:0] OFS_MASK_UP = 3'h6;
    localparam logic [2:0] OFS_MASK_LO = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMD_EXT = 3;
    localparam int CMD_RAK = 2;
    localparam int CMD_RNW = 1;
    localparam int CMD_RTR = 0;
    localparam int PTR_SPY = 7;
    localparam int LEN_ERR = 2;
    localparam int LEN_TX  = 1;
    localparam int LEN_RX  = 0;
    localparam logic [4:0] LEN_LINK = 5'h00;
    localparam logic [4:0] LEN_MAX  = 5'h1F;

    // ------------------------------------------------------------
    // Host-side APB map
    // ------------------------------------------------------------
    localparam logic [11:0] HOST_CMD  = 12'h000;
    localparam logic [11:0] HOST_STAT = 12'h004;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_WRITE    = 16;
    localparam int CMD_GO       = 31;
    localparam int STAT_BUSY    = 8;
    localparam logic [16:0] CMD_RST = 17'h00000;

    // ------------------------------------------------------------
    // Message type decode from rnw, rtr, transmitted, received
    // ------------------------------------------------------------
    function automatic logic rx_type(input logic rnw, rtr, tx, rx);
        return (!rnw && rtr && !rx) || (rnw && rtr && !rx) || (rnw && !rtr && tx && !rx);
    endfunction

    function automatic logic tx_type(input logic rnw, rtr, tx, rx);
        return (!rnw && !rtr && !tx) || (rnw && rtr && !tx && !rx) || (rnw && !rtr && !tx);
    endfunction

endpackage

// File: core/host_bus_if.sv
// Byte bus between the host controller and the channel block.
// Assumes both ends run on the same pclk.
`timescale 1ns/100ps
interface host_bus_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ready;
    logic       rvalid;
    logic [7:0] rdata;

    modport dev  (input  req, we, addr, wdata, output ready, rvalid, rdata);
    modport host (output req, we, addr, wdata, input  ready, rvalid, rdata);
endinterface

// File: core/chan_match.sv
// Masked identifier compare with lowest-channel priority.
// Assumes the caller supplies per-channel enables already decoded.
`timescale 1ns/100ps
module chan_match import chan_pkg::*; (
    // Received header
    input  wire logic [11:0]              ident,
    input  wire logic                     ext,
    // Channel set
    input  wire logic [NUM_CH-1:0][11:0]  tags,
    input  wire logic [NUM_CH-1:0][11:0]  masks,
    input  wire logic [NUM_CH-1:0]        exts,
    input  wire logic [NUM_CH-1:0]        enables,
    // Result
    output logic                          hit,
    output logic [3:0]                    idx
);
    always_comb begin
        hit = 1'b0;
        idx = 4'h0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (enables[i] && (exts[i] == ext) && (((tags[i] ^ ident) & masks[i]) == 12'h000)) begin
                hit = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule

// File: core/chan_mailbox_dev.sv
// Channel register sets, acceptance filter and mailbox RAM.
// Assumes a frame engine on pclk drives the rx and tx event ports.
`timescale 1ns/100ps
module chan_mailbox_dev import chan_pkg::*; (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Host byte bus
    host_bus_if.dev                  bus,
    // Frame engine, receive side
    input  wire logic                rx_hdr_valid,
    input  wire logic [11:0]         rx_ident,
    input  wire logic [3:0]          rx_cmd,
    input  wire logic                rx_byte_valid,
    input  wire logic [7:0]          rx_byte,
    input  wire logic                rx_end,
    input  wire logic                rx_good,
    // Frame engine, transmit side
    input  wire logic                tx_done,
    input  wire logic [3:0]          tx_ch,
    input  wire logic                tx_good,
    input  wire logic                tx_retry_over,
    // Results
    output logic                     rx_hit,
    output logic [3:0]               rx_hit_ch,
    output logic                     rx_send_ack,
    output logic                     receive_acked_ok_irq,
    output logic                     receive_unacked_ok_irq,
    output logic [NUM_CH-1:0]        tx_pending
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Channel sets and mailbox are left unreset; software must fill them
    logic [7:0] id_up_q  [NUM_CH];
    logic [7:0] id_lo_q  [NUM_CH];
    logic [7:0] ptr_q    [NUM_CH];
    logic [7:0] len_q    [NUM_CH];
    logic [7:0] mask_up_q[NUM_CH];
    logic [3:0] mask_lo_q[NUM_CH];
    logic [7:0] mbox_q   [MBOX_DEPTH];

    // ------------------------------------------------------------
    // Per-channel decode
    // ------------------------------------------------------------
    logic [NUM_CH-1:0][11:0] tags;
    logic [NUM_CH-1:0][11:0] masks;
    logic [NUM_CH-1:0]       exts;
    logic [NUM_CH-1:0]       rx_en;
    logic [3:0]              bidx [NUM_CH];
    logic                    hit;
    logic [3:0]              hit_idx;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            tags[i]  = {id_up_q[i], id_lo_q[i][7:4]};
            masks[i] = {mask_up_q[i], mask_lo_q[i]};
            exts[i]  = id_lo_q[i][CMD_EXT];
            // One level only: a link resolves to the named channel's own fields
            if (len_q[i][7:3] == LEN_LINK && ptr_q[i][3:0] < 4'(NUM_CH))
                bidx[i] = ptr_q[i][3:0];
            else
                bidx[i] = 4'(i);
            rx_en[i] = rx_type(id_lo_q[i][CMD_RNW], id_lo_q[i][CMD_RTR],
                               len_q[i][LEN_TX], len_q[bidx[i]][LEN_RX]);
        end
    end

    chan_match u_match (
        .ident   (rx_ident),
        .ext     (rx_cmd[CMD_EXT]),
        .tags    (tags),
        .masks   (masks),
        .exts    (exts),
        .enables (rx_en),
        .hit     (hit),
        .idx     (hit_idx)
    );

    // ------------------------------------------------------------
    // Receive sequence
    // ------------------------------------------------------------
    logic       act_q;
    logic [3:0] ch_q;
    logic [3:0] buf_q;
    logic [2:0] cmd_q;
    logic [4:0] cnt_q;
    logic [6:0] bptr;
    logic [4:0] blen;
    logic       hit_wr;
    logic       byte_wr;
    logic       end_wr;
    logic       tx_wr;
    logic [4:0] rlen;

    assign bptr    = ptr_q[buf_q][6:0];
    assign blen    = len_q[buf_q][7:3];
    assign hit_wr  = rx_hdr_valid && hit;
    assign byte_wr = act_q && rx_byte_valid && !rx_hdr_valid && (cnt_q + 5'h01 < blen);
    assign end_wr  = act_q && rx_end && !rx_hdr_valid;
    assign tx_wr   = tx_done && tx_ch < 4'(NUM_CH);
    assign rlen    = (cnt_q == LEN_MAX) ? LEN_MAX : cnt_q + 5'h01;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'b0;
            ch_q  <= 4'h0;
            buf_q <= 4'h0;
            cmd_q <= 3'h0;
            cnt_q <= 5'h00;
        end else if (rx_hdr_valid) begin
            act_q <= hit;
            ch_q  <= hit_idx;
            buf_q <= bidx[hit_idx];
            cmd_q <= rx_cmd[2:0];
            cnt_q <= 5'h00;
        end else begin
            if (rx_end)
                act_q <= 1'b0;
            if (act_q && rx_byte_valid && cnt_q != LEN_MAX)
                cnt_q <= cnt_q + 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hit                 <= 1'b0;
            rx_hit_ch              <= 4'h0;
            rx_send_ack            <= 1'b0;
            receive_acked_ok_irq   <= 1'b0;
            receive_unacked_ok_irq <= 1'b0;
        end else begin
            rx_hit                 <= hit_wr;
            rx_hit_ch              <= hit_wr ? hit_idx : rx_hit_ch;
            rx_send_ack            <= hit_wr ? (rx_cmd[CMD_RAK] && !ptr_q[hit_idx][PTR_SPY])
                                             : (rx_send_ack && !rx_end);
            receive_acked_ok_irq   <= end_wr && rx_good && cmd_q[CMD_RAK];
            receive_unacked_ok_irq <= end_wr && rx_good && !cmd_q[CMD_RAK];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_pending <= '0;
        else
            for (int i = 0; i < NUM_CH; i++)
                tx_pending[i] <= !len_q[i][LEN_ERR] &&
                                 tx_type(id_lo_q[i][CMD_RNW], id_lo_q[i][CMD_RTR],
                                         len_q[i][LEN_TX], len_q[bidx[i]][LEN_RX]);
    end

    // ------------------------------------------------------------
    // Host access, stalled whenever the engine writes storage
    // ------------------------------------------------------------
    logic       acc;
    logic       is_ch;
    logic [3:0] hch;
    logic [2:0] hofs;

    assign bus.ready = !(hit_wr || byte_wr || end_wr || tx_wr);
    assign acc       = bus.req && bus.ready;
    assign is_ch     = !bus.addr[7] && bus.addr >= CH_BASE;
    assign hch       = bus.addr[6:3] - 4'h2;
    assign hofs      = bus.addr[2:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.rvalid <= 1'b0;
            bus.rdata  <= 8'h00;
        end else begin
            bus.rvalid <= acc && !bus.we;
            if (acc && !bus.we) begin
                if (bus.addr[7])
                    bus.rdata <= mbox_q[bus.addr[6:0]];
                else if (!is_ch)
                    bus.rdata <= 8'h00;
                else
                    unique case (hofs)
                        OFS_ID_UP:   bus.rdata <= id_up_q[hch];
                        OFS_ID_LO:   bus.rdata <= id_lo_q[hch];
                        OFS_PTR:     bus.rdata <= ptr_q[hch];
                        OFS_LEN:     bus.rdata <= len_q[hch];
                        OFS_MASK_UP: bus.rdata <= mask_up_q[hch];
                        OFS_MASK_LO: bus.rdata <= {mask_lo_q[hch], 4'h0};
                        default:     bus.rdata <= 8'h00;
                    endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Channel register file
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (acc && bus.we && is_ch) begin
            unique case (hofs)
                OFS_ID_UP:   id_up_q[hch]   <= bus.wdata;
                OFS_ID_LO:   id_lo_q[hch]   <= bus.wdata;
                OFS_PTR:     ptr_q[hch]     <= bus.wdata;
                OFS_LEN:     len_q[hch]     <= bus.wdata;
                OFS_MASK_UP: mask_up_q[hch] <= bus.wdata;
                OFS_MASK_LO: mask_lo_q[hch] <= bus.wdata[7:4];
                default: ;
            endcase
        end
        if (hit_wr) begin
            id_up_q[hit_idx]      <= rx_ident[11:4];
            id_lo_q[hit_idx][7:4] <= rx_ident[3:0];
        end
        if (end_wr) begin
            if (rx_good)
                len_q[buf_q][LEN_RX] <= 1'b1;
            else
                len_q[ch_q][LEN_ERR] <= 1'b1;
        end
        if (tx_wr) begin
            if (tx_good || tx_retry_over)
                len_q[tx_ch][LEN_TX] <= 1'b1;
            if (!tx_good)
                len_q[tx_ch][LEN_ERR] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Mailbox RAM; 7-bit sums wrap 0xFF back to 0x80
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (acc && bus.we && bus.addr[7])
            mbox_q[bus.addr[6:0]] <= bus.wdata;
        if (byte_wr)
            mbox_q[bptr + 7'h01 + 7'(cnt_q)] <= rx_byte;
        if (end_wr && rx_good)
            mbox_q[bptr] <= {rlen, cmd_q};
    end

endmodule

// File: core/chan_host_ctrl.sv
// Host end: APB slave taking byte-bus orders from software.
// Assumes the channel block answers on the shared host_bus_if.
`timescale 1ns/100ps
module chan_host_ctrl import chan_pkg::*; (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Byte bus to the channel block
    host_bus_if.host         bus
);

    // ------------------------------------------------------------
    // Order and status
    // ------------------------------------------------------------
    logic [16:0] cmd_q;
    logic        busy_q;
    logic        wait_q;
    logic [7:0]  rdata_q;
    logic        wr_acc;
    logic        mapped;

    assign mapped  = paddr == HOST_CMD || paddr == HOST_STAT;
    assign wr_acc  = psel && penable && pwrite && paddr == HOST_CMD;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = (paddr == HOST_STAT) ? {23'h000000, busy_q, rdata_q} :
                     (paddr == HOST_CMD)  ? {15'h0000, cmd_q} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q   <= CMD_RST;
            busy_q  <= 1'b0;
            wait_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            // An order while busy is ignored
            if (wr_acc && pwdata[CMD_GO] && !busy_q) begin
                cmd_q  <= pwdata[16:0];
                busy_q <= 1'b1;
            end else if (busy_q && !wait_q && bus.ready) begin
                if (cmd_q[CMD_WRITE])
                    busy_q <= 1'b0;
                else
                    wait_q <= 1'b1;
            end else if (wait_q && bus.rvalid) begin
                rdata_q <= bus.rdata;
                wait_q  <= 1'b0;
                busy_q  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Byte bus drive
    // ------------------------------------------------------------
    assign bus.req   = busy_q && !wait_q;
    assign bus.we    = cmd_q[CMD_WRITE];
    assign bus.addr  = cmd_q[CMD_ADDR_LSB +: 8];
    assign bus.wdata = cmd_q[CMD_DATA_LSB +: 8];

endmodule

// File: sim/chan_bus_properties.sv
// Concurrent checks on the byte bus joining the host end and the channel end.
// Assumes one clock domain, pclk, with active-low asynchronous presetn.
`timescale 1ns/100ps
module chan_bus_properties import chan_pkg::*; (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Byte bus
    input  wire logic       req,
    input  wire logic       we,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       ready,
    input  wire logic       rvalid,
    input  wire logic [7:0] rdata
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire rd_acc = req && ready && !we;
    wire in_ch  = (addr >= CH_BASE) && (addr < MBOX_BASE);

    a_read_answer_once: assert property (rd_acc |=> rvalid ##1 !rvalid)
        else $error("read answer missing or too long");
    a_rvalid_has_cause: assert property (rvalid |-> $past(rd_acc))
        else $error("read answer without accepted read");
    a_req_holds_stalled: assert property (req && !ready |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("stalled request changed");
    a_req_drops_after: assert property (req && ready |=> !req)
        else $error("request stayed up after acceptance");
    a_low_page_zero: assert property (rd_acc && addr < CH_BASE |=> rdata == 8'h00)
        else $error("low page read not zero");
    a_gap_reads_zero: assert property (rd_acc && in_ch && addr[2:1] == 2'b10 |=> rdata == 8'h00)
        else $error("unused channel offset read not zero");
    a_mask_nibble_zero: assert property (rd_acc && in_ch && addr[2:0] == OFS_MASK_LO |=> rdata[3:0] == 4'h0)
        else $error("mask low nibble not zero");
    a_rdata_holds: assert property (!rd_acc |=> $stable(rdata))
        else $error("read data changed without a read");

    c_read: cover property (rd_acc ##1 rvalid);
    c_write: cover property (req && ready && we);
    c_stall: cover property (req && !ready);
endmodule

// File: sim/van_channel_filter_mailbox_tb_top.sv
// Self-checking bench: APB software side and frame engine stimulus around both ends.
// Assumes the byte map and host order layout of chan_pkg.
`timescale 1ns/100ps
module van_channel_filter_mailbox_tb_top import chan_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr, rx_ident;
    logic [31:0] pwdata, prdata, q;
    logic rx_hdr_valid, rx_byte_valid, rx_end, rx_good, tx_done, tx_good, tx_retry_over;
    logic rx_hit, rx_send_ack, receive_acked_ok_irq, receive_unacked_ok_irq;
    logic [3:0] rx_cmd, tx_ch, rx_hit_ch;
    logic [7:0] rx_byte, rd;
    logic [NUM_CH-1:0] tx_pending;
    logic [7:0] mem [256];
    int err_count, comparisons, seed;

    host_bus_if u_host_bus_if ();
    chan_host_ctrl u_chan_host_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .bus(u_host_bus_if.host));
    chan_mailbox_dev u_chan_mailbox_dev (.pclk, .presetn, .bus(u_host_bus_if.dev), .rx_hdr_valid,
        .rx_ident, .rx_cmd, .rx_byte_valid, .rx_byte, .rx_end, .rx_good, .tx_done, .tx_ch, .tx_good,
        .tx_retry_over, .rx_hit, .rx_hit_ch, .rx_send_ack, .receive_acked_ok_irq,
        .receive_unacked_ok_irq, .tx_pending);
    chan_bus_properties u_chan_bus_properties (.pclk, .presetn, .req(u_host_bus_if.req),
        .we(u_host_bus_if.we), .addr(u_host_bus_if.addr), .wdata(u_host_bus_if.wdata),
        .ready(u_host_bus_if.ready), .rvalid(u_host_bus_if.rvalid), .rdata(u_host_bus_if.rdata));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Software side
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            if (++n > 50) begin
                err_count++;
                tally_and_finish();
            end
            @(posedge pclk);
        end
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One byte order, then poll until the host end is idle
    task automatic byte_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, HOST_CMD, {1'b1, 14'h0000, w, d, a});
        for (n = 0; n < 50; n++) begin
            apb(1'b0, HOST_STAT, 32'h00000000);
            if (q[STAT_BUSY] === 1'b0)
                break;
        end
        if (n == 50) begin
            err_count++;
            tally_and_finish();
        end
        rd = q[7:0];
    endtask
    // What a read-back of a written byte should show
    function automatic logic [7:0] seen(input logic [7:0] a, input logic [7:0] d);
        if (a < CH_BASE || (a < MBOX_BASE && a[2:1] == 2'b10))
            return 8'h00;
        if (a < MBOX_BASE && a[2:0] == OFS_MASK_LO)
            return {d[7:4], 4'h0};
        return d;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        byte_op(1'b1, a, d);
        mem[a] = seen(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a);
        byte_op(1'b0, a, 8'h00);
        chk_val(16'(rd), 16'(mem[a]));
    endtask
    task automatic rd_all(input logic [7:0] l[$]);
        foreach (l[i]) rd_chk(l[i]);
    endtask
    task automatic cfg(input logic [7:0] b, i0, i1, p, n, m0, m1);
        wr(b, i0);
        wr(b + 8'h01, i1);
        wr(b + 8'h02, p);
        wr(b + 8'h03, n);
        wr(b + 8'h06, m0);
        wr(b + 8'h07, m1);
    endtask

    // ------------------------------------------------------------
    // Frame engine side
    // ------------------------------------------------------------
    task automatic hdr(input logic [11:0] id, input logic [3:0] cmd, input logic hit);
        @(posedge pclk);
        rx_hdr_valid <= 1'b1;
        rx_ident <= id;
        rx_cmd <= cmd;
        @(posedge pclk);
        rx_hdr_valid <= 1'b0;
        #1 chk_flag(rx_hit, hit);
    endtask
    task automatic data(input int n, input logic [6:0] ptr, input int keep);
        logic [7:0] b;
        for (int k = 0; k < n; k++) begin
            b = 8'($random(seed));
            @(posedge pclk);
            rx_byte_valid <= 1'b1;
            rx_byte <= b;
            if (k < keep)
                mem[{1'b1, 7'(ptr + 7'(k) + 7'h01)}] = b;
        end
        @(posedge pclk);
        rx_byte_valid <= 1'b0;
    endtask
    task automatic fin(input logic good, input logic ack, input logic nack);
        @(posedge pclk);
        rx_end <= 1'b1;
        rx_good <= good;
        @(posedge pclk);
        rx_end <= 1'b0;
        #1 chk_flag(receive_acked_ok_irq, ack);
        chk_flag(receive_unacked_ok_irq, nack);
        chk_flag(rx_send_ack, 1'b0);
    endtask
    task automatic txev(input logic good, input logic over);
        @(posedge pclk);
        tx_done <= 1'b1;
        tx_ch <= 4'h7;
        tx_good <= good;
        tx_retry_over <= over;
        @(posedge pclk);
        tx_done <= 1'b0;
    endtask

    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end

    initial begin
        seed = 32'hc599a8a8;
        {err_count, comparisons} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_hdr_valid, rx_ident, rx_cmd, rx_byte_valid, rx_byte, rx_end, rx_good} = '0;
        {tx_done, tx_ch, tx_good, tx_retry_over} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Random fill, every channel parked inactive
        for (int a = 0; a < 256; a++)
            wr(8'(a), (a >= 16 && a < 128 && a % 8 == 3) ? 8'h0B : 8'($random(seed)));
        for (int a = 0; a < 256; a++)
            rd_chk(8'(a));
        chk_val(16'(tx_pending), 16'h0000);
        cfg(8'h38, 8'hA5, 8'h39, 8'h7E, 8'h20, 8'hFF, 8'h00);
        cfg(8'h60, 8'hA5, 8'h59, 8'h82, 8'h00, 8'hFF, 8'h00);
        cfg(8'h20, 8'h00, 8'h00, 8'h10, 8'h12, 8'h00, 8'h00);
        cfg(8'h28, 8'h12, 8'h31, 8'h40, 8'h18, 8'hFF, 8'hF0);
        cfg(8'h48, 8'h00, 8'h00, 8'h50, 8'h10, 8'h00, 8'h00);
        chk_val(16'(tx_pending), 16'h0080);
        // Overlong frame into a wrapping buffer, two channels match
        hdr(12'hA5C, 4'hF, 1'b1);
        chk_val(16'(rx_hit_ch), 16'h0005);
        chk_flag(rx_send_ack, 1'b1);
        data(5, 7'h7E, 3);
        fin(1'b1, 1'b1, 1'b0);
        mem[8'h39] = 8'hC9;
        mem[8'h3B] = 8'h21;
        mem[8'hFE] = 8'h37;
        byte_op(1'b0, 8'hFE, 8'h00);
        chk_val(16'(rd & 8'h07), 16'h0007);
        rd_all('{8'h39, 8'h3B, 8'hFE, 8'hFF, 8'h80, 8'h81, 8'h82, 8'h60, 8'h61, 8'h63});
        // Second match goes to the spying, linked channel
        hdr(12'hA5D, 4'hE, 1'b1);
        chk_val(16'(rx_hit_ch), 16'h000A);
        chk_flag(rx_send_ack, 1'b0);
        data(1, 7'h10, 1);
        fin(1'b1, 1'b1, 1'b0);
        mem[8'h90] = 8'h16;
        mem[8'h23] = 8'h13;
        mem[8'h61] = 8'hD9;
        rd_all('{8'h90, 8'h91, 8'h23, 8'h61, 8'h63, 8'h3B});
        // Extension bit and enabled mask bits must match; bad end flags an error
        hdr(12'h123, 4'h9, 1'b0);
        hdr(12'h122, 4'h1, 1'b0);
        hdr(12'h123, 4'h1, 1'b1);
        chk_val(16'(rx_hit_ch), 16'h0003);
        data(2, 7'h40, 2);
        fin(1'b0, 1'b0, 1'b0);
        mem[8'h2B] = 8'h1C;
        rd_all('{8'h2B, 8'hC1, 8'hC2});
        wr(8'h2B, 8'h18);
        rd_chk(8'h2B);
        // Good frame without acknowledge request
        hdr(12'h123, 4'h1, 1'b1);
        chk_val(16'(rx_hit_ch), 16'h0003);
        chk_flag(rx_send_ack, 1'b0);
        data(1, 7'h40, 1);
        fin(1'b1, 1'b0, 1'b1);
        mem[8'hC0] = 8'h11;
        mem[8'h2B] = 8'h19;
        rd_all('{8'hC0, 8'hC1, 8'h2B});
        // Transmit side: abort, failure, success under a stalled read, retry overflow
        wr(8'h4B, 8'h14);
        chk_val(16'(tx_pending), 16'h0000);
        wr(8'h4B, 8'h10);
        chk_val(16'(tx_pending), 16'h0080);
        txev(1'b0, 1'b0);
        mem[8'h4B] = 8'h14;
        rd_chk(8'h4B);
        wr(8'h4B, 8'h10);
        fork
            byte_op(1'b0, 8'h4B, 8'h00);
            begin
                repeat (2) @(posedge pclk);
                txev(1'b1, 1'b0);
            end
        join
        chk_val(16'(rd), 16'h0012);
        chk_val(16'(tx_pending), 16'h0000);
        wr(8'h4B, 8'h10);
        txev(1'b0, 1'b1);
        mem[8'h4B] = 8'h16;
        rd_chk(8'h4B);
        // Host map: order read-back and an unmapped address
        apb(1'b0, HOST_CMD, 32'h00000000);
        chk_val(q[15:0], 16'h004B);
        chk_flag(q[16], 1'b0);
        chk_flag(slv, 1'b0);
        apb(1'b0, 12'h008, 32'h00000000);
        chk_flag(slv, 1'b1);
        chk_val(q[15:0], 16'h0000);
        tally_and_finish();
    end
endmodule
